// File: bench/tb_top.sv
// Self-checking bench for the reset-exit attach logic
`timescale 1ns/10ps
module tb_top;
    import ure_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] bus_cmd = 2'h2;
    logic ovr = 1'b0;
    logic pkt = 1'b0;
    logic usb_dp, usb_dm, connected, pkt_accept, in_reset;
    logic [2:0] notes[$];
    logic [2:0] exp_v;
    logic [31:0] seed = 32'd70866;
    int bad_count = 0;
    int compares = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    ure_host_model u_host (.bus_cmd(bus_cmd), .usb_dp(usb_dp),
        .usb_dm(usb_dm));
    // Short counts keep the run brief
    ure_reset_exit #(.IDLE_COUNT(20), .SE0_COUNT(4)) u_dut (.clk(clk),
        .resetn(resetn), .usb_dp(usb_dp), .usb_dm(usb_dm),
        .debug_override_input(ovr), .pkt_valid(pkt),
        .connected(connected), .pkt_accept(pkt_accept),
        .in_reset(in_reset));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic hold(input logic [1:0] c, input int n);
        bus_cmd = c;
        repeat (n) @(negedge clk);
    endtask
    // Expected {connected, in_reset, accept} after next edge
    task automatic note(input logic [2:0] e);
        notes.push_back(e);
        @(negedge clk);
    endtask
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Monitor checks settled outputs after each edge
    always @(posedge clk)
    begin
        #10;
        if (notes.size() > 0)
        begin
            exp_v = notes.pop_front();
            compares++;
            if ({connected, in_reset, pkt_accept} !== exp_v)
            begin
                bad_count++;
                $display("Error status exp %b seen %b", exp_v,
                    {connected, in_reset, pkt_accept});
            end
        end
    end
    // Watchdog at 2000 cycles, far beyond the under two hundred cycles needed
    initial
    begin
        #80000;
        bad_count++;
        give_verdict();
    end
    initial
    begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        note(3'h0);
        hold(2'h2, 10);
        note(3'h2);
        pkt = 1'b1;
        note(3'h2);
        pkt = 1'b0;
        // Short J runs broken by other traffic; sum exceeds idle count
        repeat (6)
        begin
            hold(2'h0, 12);
            seed = xs(seed);
            hold(seed[0] ? 2'h1 : 2'h2, 1 + seed[1]);
        end
        note(3'h2);
        hold(2'h0, 30);
        note(3'h4);
        pkt = 1'b1;
        note(3'h5);
        pkt = 1'b0;
        note(3'h4);
        hold(2'h2, 10);
        note(3'h2);
        // Override makes busy K traffic look idle
        ovr = 1'b1;
        hold(2'h1, 30);
        note(3'h4);
        ovr = 1'b0;
        give_verdict();
    end
endmodule // tb_top

// File: bench/ure_host_model.sv
// Host-side line driver model for the attach logic
`timescale 1ns/10ps
module ure_host_model (
    // Line state request: 0 J, 1 K, 2 SE0
    input wire logic [1:0] bus_cmd,
    // Bus lines
    output logic usb_dp,
    output logic usb_dm
);
    // Full speed J is DP high; bus reset is SE0
    assign usb_dp = (bus_cmd == 2'h0);
    assign usb_dm = (bus_cmd == 2'h1);
endmodule // ure_host_model

// File: hw/ure_pkg.sv
// Constants for the USB device reset-exit attach logic
package ure_pkg;
    // Required contiguous idle time after bus reset
    localparam int IDLE_TIME_US = 800;
    localparam int CLK_MHZ = 25;
    localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
    // Bus reset: SE0 held at least 2.5 us
    localparam int SE0_RESET_NS = 2500;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SE0_RESET_CYCLES =
        (SE0_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // Synchroniser lanes DP, DM, override; DP rests high like an idle bus
    localparam int SYNC_LANES = 3;
    localparam logic [SYNC_LANES-1:0] SYNC_RESET_VAL = 3'h1;
    // Attach states
    typedef enum logic [1:0] {
        URE_DETACHED = 2'b00,
        URE_RESET = 2'b01,
        URE_CONNECTED = 2'b10
    } ure_state_type;
endpackage

// File: hw/ure_reset_exit.sv
// Attach-state logic that leaves bus reset after a contiguous idle J period
//
// Operation
// - After bus reset, connect only after 800 us of unbroken J.
// - Before connected, no connect is shown and no packet accepted.
// - Any bus activity, even for other addresses, counts as not idle.
// - The controller runs only at full speed, where J is DP high and DM low.
// - A debug override input forces the seen lines to DP one and DM zero.
`timescale 1ns/10ps
module ure_reset_exit
#(
    parameter int IDLE_COUNT = ure_pkg::IDLE_CYCLES,
    parameter int SE0_COUNT = ure_pkg::SE0_RESET_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bus line receivers, asynchronous
    input wire logic usb_dp,
    input wire logic usb_dm,
    // Debug override, asynchronous pin
    input wire logic debug_override_input,
    // Packet strobe from the receiver on clk
    input wire logic pkt_valid,
    // Status
    output logic connected,
    output logic pkt_accept,
    output logic in_reset
);
    import ure_pkg::*;

    // Counters are CNT_W wide; an IDLE_COUNT beyond that never ends
    logic [CNT_W-1:0] idle_q, idle_d, se0_q, se0_d;
    ure_state_type state_q, state_d;
    logic connected_q, accept_q;

    // Raw pins by lane: bit 0 DP, bit 1 DM, bit 2 override
    wire [SYNC_LANES-1:0] pins_raw = {debug_override_input, usb_dm, usb_dp};
    wire [SYNC_LANES-1:0] lines_sync;

    // Two-flop synchroniser per lane; stage one feeds only stage two.
    // Reset levels match the idle bus so no false SE0 follows reset.
    genvar lane;
    generate
        for (lane = 0; lane < SYNC_LANES; lane++)
        begin : g_sync
            logic s1_q, s2_q;
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    s1_q <= SYNC_RESET_VAL[lane];
                    s2_q <= SYNC_RESET_VAL[lane];
                end
                else
                begin
                    s1_q <= pins_raw[lane];
                    s2_q <= s1_q;
                end
            end
            assign lines_sync[lane] = s2_q;
        end
    endgenerate

    // Lanes by name after the second stage
    wire sync_dp = lines_sync[0];
    wire sync_dm = lines_sync[1];
    wire sync_ov = lines_sync[2];

    // Seen lines; override wins over pins
    wire seen_dp = sync_ov | sync_dp;
    wire seen_dm = ~sync_ov & sync_dm;
    // Full-speed J: DP high, DM low; anything else is activity
    wire bus_j = seen_dp & ~seen_dm;
    wire bus_se0 = ~seen_dp & ~seen_dm;
    wire idle_done = (32'(idle_q) >= IDLE_COUNT - 1);
    wire se0_done = (32'(se0_q) >= SE0_COUNT - 1);

    // Idle timer restarts on any non-J; counts only in reset state
    assign idle_d = (state_q != URE_RESET || !bus_j) ? '0 :
                    (idle_done ? idle_q : idle_q + CNT_W'(1'h1));
    // SE0 length counter, saturating, detects bus reset
    assign se0_d = !bus_se0 ? '0 :
                   (se0_done ? se0_q : se0_q + CNT_W'(1'h1));

    // State transitions
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            URE_DETACHED:
                if (bus_se0 && se0_done)
                    state_d = URE_RESET;
            URE_RESET:
                if (bus_j && idle_done)
                    state_d = URE_CONNECTED;
            URE_CONNECTED:
                if (bus_se0 && se0_done)
                    state_d = URE_RESET;
            default:
                state_d = URE_DETACHED;
        endcase
    end

    // State, counters and registered outputs
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= URE_DETACHED;
            idle_q <= '0;
            se0_q <= '0;
            connected_q <= 1'h0;
            accept_q <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            idle_q <= idle_d;
            se0_q <= se0_d;
            connected_q <= (state_d == URE_CONNECTED);
            accept_q <= (state_q == URE_CONNECTED) && pkt_valid;
        end
    end

    assign connected = connected_q;
    assign pkt_accept = accept_q;
    assign in_reset = (state_q == URE_RESET);

    // All checks run on clk and rest while reset is held
    default clocking assert_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Steps of the reset exit
    sequence j_in_reset_s;
        state_q == URE_RESET && bus_j;
    endsequence
    sequence leave_reset_s;
        state_q == URE_RESET && state_d == URE_CONNECTED;
    endsequence
    sequence se0_long_s;
        bus_se0 && se0_done;
    endsequence

    // Leaving reset needs a full unbroken J run
    property full_idle_p;
        leave_reset_s |-> (32'(idle_q) == IDLE_COUNT - 1) && bus_j;
    endproperty
    connect_idle_a: assert property (full_idle_p)
        else $error("connected without full idle period");

    // Timer end with J still seen must connect at once
    property idle_reach_p;
        (j_in_reset_s ##0 idle_done) |=> connected && !in_reset;
    endproperty
    idle_reach_a: assert property (idle_reach_p)
        else $error("full idle period did not connect");

    // No connect or accept before connected state
    property no_early_accept_p;
        (state_q != URE_CONNECTED) |=> !pkt_accept;
    endproperty
    no_early_accept_a: assert property (no_early_accept_p)
        else $error("packet accepted before connected");

    property connect_flag_p;
        connected |-> state_q == URE_CONNECTED;
    endproperty
    connect_flag_a: assert property (connect_flag_p)
        else $error("connect shown outside connected state");

    // Once connected, every strobe is taken one cycle later
    property accept_follow_p;
        (state_q == URE_CONNECTED && pkt_valid) |=> pkt_accept;
    endproperty
    accept_follow_a: assert property (accept_follow_p)
        else $error("packet dropped while connected");

    // Non-J clears the timer and keeps the reset state
    property activity_clear_p;
        (state_q == URE_RESET && !bus_j) |=> idle_q == '0;
    endproperty
    activity_clear_a: assert property (activity_clear_p)
        else $error("idle timer survived bus activity");

    property busy_hold_p;
        (state_q == URE_RESET && !bus_j) |=> in_reset && !connected;
    endproperty
    busy_hold_a: assert property (busy_hold_p)
        else $error("left reset during bus activity");

    // Timer steps by one per J cycle until it ends
    property idle_count_p;
        (j_in_reset_s ##0 !idle_done) |=>
        idle_q == $past(idle_q) + CNT_W'(1'h1);
    endproperty
    idle_count_a: assert property (idle_count_p)
        else $error("idle timer not counting");

    bus_reset_a: assert property (se0_long_s |=> in_reset)
        else $error("bus reset not entered");

    // Detached state only leaves on a long SE0
    property detached_quiet_p;
        (state_q == URE_DETACHED && !(bus_se0 && se0_done)) |=>
        !in_reset && !connected;
    endproperty
    detached_quiet_a: assert property (detached_quiet_p)
        else $error("left detached without bus reset");

    // Override must read as J whatever the pins carry
    override_j_a: assert property (sync_ov |-> bus_j)
        else $error("override does not give J");

    // Full speed J only with DP high and DM low
    speed_j_a: assert property ((!sync_ov && sync_dm) |-> !bus_j)
        else $error("DM high taken as J");

    dp_low_a: assert property ((!sync_ov && !sync_dp) |-> !bus_j)
        else $error("DP low taken as J");

endmodule // ure_reset_exit
